/* File: rtl/branch_pkg.sv */
// Package: constants and carriers for the branch condition unit
package branch_pkg;
	// Instruction field positions
	localparam int TYPE_HI       = 31;
	localparam int TYPE_LO       = 30;
	localparam int OPC_HI        = 29;
	localparam int OPC_LO        = 27;
	localparam int PHASE_HI      = 26;
	localparam int PHASE_LO      = 24;
	localparam int REL_BIT       = 23;
	localparam int CARRY_BIT     = 21;
	localparam int ONFLY_BIT     = 20;
	localparam int TRUE_BIT      = 19;
	localparam int DATA_BIT      = 18;
	localparam int PHASE_BIT     = 17;
	localparam int WAIT_BIT      = 16;
	localparam int MASK_HI       = 15;
	localparam int MASK_LO       = 8;
	localparam int VALUE_HI      = 7;
	localparam int VALUE_LO      = 0;
	localparam int OFFSET_W      = 24;
	localparam int ONFLY_STAT    = 2;
	// Type code of transfer control
	localparam logic [1:0] TYPE_XFER = 2'h2;
	// Pointer advance after a fetch
	localparam logic [31:0] PTR_STEP = 32'h0000_0004;
	// Reset values
	localparam logic [31:0] PTR_RST  = 32'h0000_0000;
	localparam logic [7:0]  STAT_RST = 8'h00;

	// Transfer control opcodes
	typedef enum logic [2:0] {
		OP_JUMP   = 3'h0,
		OP_CALL   = 3'h1,
		OP_RETURN = 3'h2,
		OP_INT    = 3'h3
	} opcode_e;

	// Bus phase encodings
	typedef enum logic [2:0] {
		PH_DATA_OUT = 3'h0,
		PH_DATA_IN  = 3'h1,
		PH_COMMAND  = 3'h2,
		PH_STATUS   = 3'h3,
		PH_RES_OUT  = 3'h4,
		PH_RES_IN   = 3'h5,
		PH_MSG_OUT  = 3'h6,
		PH_MSG_IN   = 3'h7
	} phase_e;

	// One two-word instruction from the fetch path
	typedef struct packed {
		logic [31:0] cmd;
		logic [31:0] addr;
	} instr_s;

	// Bus side state seen by the compares
	typedef struct packed {
		logic [2:0] phase;
		logic       req_new;
		logic       atn;
		logic       initiator;
		logic [7:0] first_byte;
		logic       carry;
	} bus_s;
endpackage

/* File: rtl/branch_condition_unit.sv */
// Decoder and executor for transfer control instructions
// What this block does
// - Decode type 10 as transfer control; opcodes jump, call, return, interrupt.
// - Taken jump loads pointer from the instruction's address word.
// - Untaken branch leaves pointer unchanged; next fetch from it.
// - Taken call saves pointer into single save register first.
// - Taken return loads pointer from the save register.
// - Return never checks for a prior call; no error raised.
// - Satisfied interrupt asserts active low interrupt request.
// - Address holding register keeps the 32-bit field for host.
// - Halting interrupt stops; host pointer write restarts.
// - Bit 20 interrupt does not halt; sets status bit 2.
// - Phase field 26-24 compares with the current bus phase lines.
// - Bit 23 on jump or call adds sign-extended 24-bit offset.
// - Relative targets use two's complement, +/-8 MB reach.
// - Bit 21 tests carry; software never mixes it with compares.
// - Branch when compare result equals bit 19.
// - Both compares enabled: both match, or both mismatch.
// - Bit 18 compares first received byte with bits 7-0.
// - Set mask bits ignore those byte positions.
// - Bit 17 compares phase as initiator, tests attention as target.
// - Bit 16 waits for a new unserviced request before a phase or data compare.
// - After fetching a jump target, pointer advances by 4.
`timescale 1ns/1ps
module branch_condition_unit
	import branch_pkg::*;
(
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               rst,
	// Instruction from the fetch path
	input  wire logic               instr_valid,
	input  wire branch_pkg::instr_s instr,
	output logic                    instr_ready,
	// Fetch handshake for pointer advance
	input  wire logic               fetch_done,
	// Bus phase and data state
	input  wire branch_pkg::bus_s   bus,
	// Host restart by pointer write, and host status clear
	input  wire logic               ptr_write,
	input  wire logic [31:0]        ptr_wdata,
	input  wire logic               status_clear,
	// Results
	output logic [31:0]             instr_ptr,
	output logic [31:0]             save_reg,
	output logic [31:0]             address_holding_reg,
	output logic [7:0]              interrupt_status_reg,
	output logic                    irq_n,
	output logic                    halted,
	output logic                    illegal,
	output logic                    req_serviced
);

	// Execution states
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1,
		ST_HALT = 2'h3
	} state_e;

	state_e      state_q, state_d;
	logic [31:0] ptr_q, ptr_d;
	logic [31:0] save_q, save_d;
	logic [31:0] hold_q, hold_d;
	logic [7:0]  stat_q, stat_d;
	logic        irq_n_q, irq_n_d;
	logic        ill_q, ill_d;
	logic        srv_q, srv_d;
	logic        adv_q, adv_d;
	logic        halt_q, halt_d;
	logic        rdy_q, rdy_d;

	// Instruction decode
	logic [2:0]  opc;
	logic        is_xfer, reserved, need_wait;
	logic        phase_hit, data_hit, carry_hit, cond, taken;
	logic [7:0]  mask;
	logic [31:0] target;

	assign opc      = instr.cmd[OPC_HI:OPC_LO];
	assign is_xfer  = instr.cmd[TYPE_HI:TYPE_LO] == TYPE_XFER;
	assign reserved = opc[2];
	assign mask     = instr.cmd[MASK_HI:MASK_LO];

	// Phase or attention compare
	always_comb begin
		if (bus.initiator) begin
			phase_hit = bus.phase == instr.cmd[PHASE_HI:PHASE_LO];
		end else begin
			phase_hit = bus.atn;
		end
	end

	// Masked byte compare and carry test
	assign data_hit  = ((bus.first_byte ^ instr.cmd[VALUE_HI:VALUE_LO])
		& ~mask) == 8'h00;
	assign carry_hit = bus.carry;

	// Combined condition
	always_comb begin
		if (instr.cmd[CARRY_BIT]) begin
			cond = carry_hit == instr.cmd[TRUE_BIT];
		end else if (instr.cmd[PHASE_BIT] && instr.cmd[DATA_BIT]) begin
			cond = (phase_hit == instr.cmd[TRUE_BIT])
				&& (data_hit == instr.cmd[TRUE_BIT]);
		end else if (instr.cmd[PHASE_BIT]) begin
			cond = phase_hit == instr.cmd[TRUE_BIT];
		end else if (instr.cmd[DATA_BIT]) begin
			cond = data_hit == instr.cmd[TRUE_BIT];
		end else begin
			cond = 1'b1;
		end
	end

	// Waiting for a fresh request applies to phase and data compares only
	assign need_wait = instr.cmd[WAIT_BIT] && !instr.cmd[CARRY_BIT]
		&& (instr.cmd[PHASE_BIT] || instr.cmd[DATA_BIT]);
	assign taken = cond;

	// Absolute or relative target, relative only on jump and call
	always_comb begin
		if (instr.cmd[REL_BIT]) begin
			target = ptr_q + {{(32 - OFFSET_W){instr.addr[OFFSET_W - 1]}},
				instr.addr[OFFSET_W - 1:0]};
		end else begin
			target = instr.addr;
		end
	end

	// Next state of the executor
	always_comb begin
		state_d = state_q;
		ptr_d   = ptr_q;
		save_d  = save_q;
		hold_d  = hold_q;
		stat_d  = stat_q;
		irq_n_d = irq_n_q;
		ill_d   = ill_q;
		srv_d   = 1'b0;
		adv_d   = adv_q;
		if (status_clear) begin
			stat_d  = STAT_RST;
			irq_n_d = 1'b1;
			ill_d   = 1'b0;
		end
		if (adv_q && fetch_done) begin
			ptr_d = ptr_q + PTR_STEP;
			adv_d = 1'b0;
		end
		case (state_q)
			ST_IDLE, ST_WAIT: begin
				if (instr_valid && is_xfer && !adv_q) begin
					hold_d = instr.addr;
					if (reserved) begin
						ill_d   = 1'b1;
						irq_n_d = 1'b0;
						state_d = ST_HALT;
					end else if (need_wait && !bus.req_new) begin
						state_d = ST_WAIT;
					end else begin
						state_d = ST_IDLE;
						srv_d   = need_wait;
						if (taken) begin
							case (opc)
								OP_JUMP: begin
									ptr_d = target;
									adv_d = 1'b1;
								end
								OP_CALL: begin
									save_d = ptr_q;
									ptr_d  = target;
									adv_d  = 1'b1;
								end
								OP_RETURN: begin
									ptr_d = save_q;
									adv_d = 1'b1;
								end
								OP_INT: begin
									// Request goes low for both kinds
									irq_n_d = 1'b0;
									if (instr.cmd[ONFLY_BIT]) begin
										stat_d[ONFLY_STAT] = 1'b1;
									end else begin
										state_d = ST_HALT;
									end
								end
								default: begin
									state_d = ST_IDLE;
								end
							endcase
						end
						// Untaken: pointer left as is
					end
				end
			end
			ST_HALT: begin
				if (ptr_write) begin
					ptr_d   = ptr_wdata;
					adv_d   = 1'b0;
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (ptr_write && state_q != ST_HALT) begin
			ptr_d = ptr_wdata;
			adv_d = 1'b0;
		end
		// Halt and ready flags kept in flops for clean outputs
		halt_d = state_d == ST_HALT;
		rdy_d  = state_d != ST_HALT && !adv_d;
	end

	// Registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			ptr_q   <= PTR_RST;
			save_q  <= PTR_RST;
			hold_q  <= PTR_RST;
			stat_q  <= STAT_RST;
			irq_n_q <= 1'b1;
			ill_q   <= 1'b0;
			srv_q   <= 1'b0;
			adv_q   <= 1'b0;
			halt_q  <= 1'b0;
			rdy_q   <= 1'b1;
		end else begin
			state_q <= state_d;
			ptr_q   <= ptr_d;
			save_q  <= save_d;
			hold_q  <= hold_d;
			stat_q  <= stat_d;
			irq_n_q <= irq_n_d;
			ill_q   <= ill_d;
			srv_q   <= srv_d;
			adv_q   <= adv_d;
			halt_q  <= halt_d;
			rdy_q   <= rdy_d;
		end
	end

	// Outputs from flip-flops
	assign instr_ptr            = ptr_q;
	assign save_reg             = save_q;
	assign address_holding_reg  = hold_q;
	assign interrupt_status_reg = stat_q;
	assign irq_n                = irq_n_q;
	assign halted               = halt_q;
	assign illegal              = ill_q;
	assign req_serviced         = srv_q;
	assign instr_ready          = rdy_q;

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_call_taken;
		instr_valid && instr_ready && is_xfer && opc == OP_CALL
			&& !reserved && taken && !(need_wait && !bus.req_new)
			&& !ptr_write;
	endsequence

	a_jump_loads: assert property (instr_valid && instr_ready && is_xfer
		&& opc == OP_JUMP && taken && !need_wait && !ptr_write
		&& !instr.cmd[REL_BIT] |=> ptr_q == $past(instr.addr))
		else $error("jump target not loaded");
	a_skip_keeps: assert property (instr_valid && instr_ready && is_xfer
		&& !reserved && !taken && !ptr_write
		&& !(adv_q && fetch_done) |=> $stable(ptr_q))
		else $error("pointer moved on untaken branch");
	a_call_saves: assert property (s_call_taken
		|=> save_q == $past(ptr_q))
		else $error("call did not save pointer");
	a_ret_loads: assert property (instr_valid && instr_ready && is_xfer
		&& opc == OP_RETURN && taken && !need_wait && !ptr_write
		|=> ptr_q == $past(save_q))
		else $error("return did not restore pointer");
	a_halt_irq: assert property (instr_valid && instr_ready && is_xfer
		&& opc == OP_INT && taken && !need_wait
		&& !instr.cmd[ONFLY_BIT] |=> !irq_n && halted)
		else $error("halting interrupt missing");
	a_hold_vector: assert property (instr_valid && instr_ready && is_xfer
		|=> address_holding_reg == $past(instr.addr))
		else $error("vector not held");
	a_halt_stays: assert property (halted && !ptr_write
		|=> halted)
		else $error("halt left without pointer write");
	a_onfly_flag: assert property (instr_valid && instr_ready && is_xfer
		&& opc == OP_INT && taken && !need_wait && instr.cmd[ONFLY_BIT]
		|=> interrupt_status_reg[ONFLY_STAT] && !halted && !irq_n)
		else $error("on-the-fly flag missing");
	a_wait_req: assert property (instr_valid && instr_ready && is_xfer
		&& !reserved && need_wait && !bus.req_new
		&& !(adv_q && fetch_done) && !ptr_write
		|=> $stable(ptr_q) && !req_serviced)
		else $error("compare did not wait for request");
	a_advance: assert property (adv_q && fetch_done && !ptr_write
		|=> ptr_q == $past(ptr_q) + PTR_STEP)
		else $error("pointer not advanced by four");
	a_reserved: assert property (instr_valid && instr_ready && is_xfer
		&& reserved |=> illegal && halted && !irq_n)
		else $error("reserved opcode not trapped");
endmodule

/* File: tb/scsi_host_side.sv */
// Far side model: bus phase logic and host interrupt service
`timescale 1ns/1ps
module scsi_host_side
	import branch_pkg::*;
#(
	parameter logic [31:0] RESTART = 32'h0000_1000
) (
	// Clock
	input  wire logic        clock,
	// Bus levels chosen by the bench
	input  wire logic [2:0]  phase_lines,
	input  wire logic [7:0]  byte_in,
	input  wire logic        carry_in,
	input  wire logic        atn_in,
	input  wire logic        initiator_in,
	input  wire logic        req_in,
	// Unit status seen by the host
	input  wire logic        irq_n,
	input  wire logic        halted,
	input  wire logic [7:0]  interrupt_status_reg,
	input  wire logic        req_serviced,
	// Toward the unit
	output branch_pkg::bus_s bus,
	output logic             ptr_write,
	output logic [31:0]      ptr_wdata,
	output logic             status_clear
);
	logic req_q = 1'b0;
	// One pending request until the unit consumes it
	always @(posedge clock) begin
		if (req_in) req_q <= 1'b1;
		else if (req_serviced) req_q <= 1'b0;
	end
	// Phase lines pass straight through, not latched at the request
	assign bus = '{phase: phase_lines, req_new: req_q, atn: atn_in,
		initiator: initiator_in, first_byte: byte_in,
		carry: carry_in};
	assign ptr_wdata = RESTART;
	// Quiet host at start
	initial begin
		ptr_write = 1'b0;
		status_clear = 1'b0;
	end
	// Host service: clear requests, restart a halted unit
	always @(negedge clock) begin
		status_clear <= !irq_n || interrupt_status_reg[2];
		ptr_write <= halted && !ptr_write;
	end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the branch condition unit
`timescale 1ns/1ps
module testbench;
	import branch_pkg::*;
	localparam logic [31:0] RESTART = 32'h0000_1000;
	typedef struct packed {
		logic [31:0] ptr;
		logic [31:0] save;
		logic [31:0] hold;
		logic        irq_n;
		logic        halted;
		logic        stat2;
		logic        ill;
		logic        srv;
	} expect_s;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic instr_valid = 1'b0;
	logic fetch_done = 1'b0;
	instr_s instr = '0;
	logic [2:0] ph_l = 3'h0;
	logic [7:0] fb = 8'h00;
	logic car = 1'b0;
	logic atn = 1'b0;
	logic ini = 1'b0;
	bus_s bus;
	logic instr_ready, ptr_write, status_clear, irq_n, halted, illegal;
	logic req_serviced;
	logic req_in = 1'b0;
	logic wt = 1'b0;
	logic [31:0] ptr_wdata, instr_ptr, save_reg, address_holding_reg;
	logic [7:0] interrupt_status_reg;
	logic acc = 1'b0;
	logic [31:0] ptr_m = '0;
	logic [31:0] save_m = '0;
	expect_s expq[$];
	int miscompares = 0;
	int comparisons = 0;

	branch_condition_unit i_branch_condition_unit (.clock(clock),
		.rst(rst), .instr_valid(instr_valid), .instr(instr),
		.instr_ready(instr_ready), .fetch_done(fetch_done), .bus(bus),
		.ptr_write(ptr_write), .ptr_wdata(ptr_wdata),
		.status_clear(status_clear), .instr_ptr(instr_ptr),
		.save_reg(save_reg), .address_holding_reg(address_holding_reg),
		.interrupt_status_reg(interrupt_status_reg), .irq_n(irq_n),
		.halted(halted), .illegal(illegal), .req_serviced(req_serviced));
	scsi_host_side #(.RESTART(RESTART)) i_scsi_host_side (.clock(clock),
		.phase_lines(ph_l), .byte_in(fb), .carry_in(car), .atn_in(atn),
		.initiator_in(ini), .req_in(req_in), .irq_n(irq_n),
		.halted(halted), .interrupt_status_reg(interrupt_status_reg),
		.req_serviced(req_serviced), .bus(bus),
		.ptr_write(ptr_write), .ptr_wdata(ptr_wdata),
		.status_clear(status_clear));

	// Clock generation
	always #2.5 clock = !clock;

	task automatic check(string n, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One transfer instruction with random condition and bus state
	task automatic run_one(input int opc);
		logic [31:0] c, a, tgt;
		logic p, d, take;
		int n;
		expect_s e;
		c = $urandom;
		a = $urandom;
		c[31:27] = {2'h2, opc[2:0]};
		ini = $urandom;
		atn = $urandom;
		car = $urandom;
		if (!ini) c[26:24] = 3'h0;
		if (c[21]) c[18:17] = 2'h0;
		if (c[21:17] == 5'h00) c[19] = 1'b1;
		wt = c[16] && !c[21] && (c[18] || c[17]) && opc < 4;
		ph_l = $urandom_range(0, 1) ? c[26:24] : 3'($urandom);
		fb = $urandom_range(0, 1) ? c[7:0] ^ (8'($urandom) & c[15:8])
			: 8'($urandom);
		p = ini ? c[26:24] == ph_l : atn;
		d = ((fb ^ c[7:0]) & ~c[15:8]) == 8'h00;
		if (c[21]) take = car == c[19];
		else if (c[18] && c[17]) take = c[19] ? p && d : !p && !d;
		else if (c[18]) take = d == c[19];
		else if (c[17]) take = p == c[19];
		else take = 1'b1;
		tgt = (c[23] && opc < 2) ? ptr_m + {{8{a[23]}}, a[23:0]} : a;
		e = '{ptr_m, save_m, a, 1'b1, 1'b0, 1'b0, 1'b0, wt};
		if (opc > 3) e = '{ptr_m, save_m, a, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		else if (take) begin
			case (opc)
				0: e.ptr = tgt;
				1: begin
					e.save = ptr_m;
					e.ptr = tgt;
				end
				2: e.ptr = save_m;
				default: begin
					e.irq_n = 1'b0;
					e.halted = !c[20];
					e.stat2 = c[20];
				end
			endcase
		end
		instr = '{cmd: c, addr: a};
		instr_valid = 1'b1;
		n = 0;
		while (!instr_ready && n < 50) begin
			@(negedge clock);
			n++;
		end
		if (n >= 50) miscompares++;
		// Held instruction waits until a fresh request arrives
		if (wt) begin
			repeat (2) @(negedge clock);
			check("waiting instr_ptr", ptr_m, instr_ptr);
			check("early req_serviced", 32'h0, 32'(req_serviced));
			req_in = 1'b1;
			@(negedge clock);
			req_in = 1'b0;
		end
		expq.push_back(e);
		@(negedge clock);
		instr_valid = 1'b0;
		ptr_m = e.ptr;
		save_m = e.save;
		if (e.halted) begin
			@(negedge clock);
			ptr_m = RESTART;
		end else if (take && opc < 3) begin
			fetch_done = 1'b1;
			@(negedge clock);
			fetch_done = 1'b0;
			ptr_m = e.ptr + PTR_STEP;
			check("advanced pointer", ptr_m, instr_ptr);
		end
		@(negedge clock);
	endtask

	// Note each accepted instruction
	always @(posedge clock)
		acc <= instr_valid && instr_ready && !rst && (!wt || bus.req_new);

	// Compare results of each accepted instruction
	always @(negedge clock) begin
		expect_s e;
		if (acc && expq.size() > 0) begin
			e = expq.pop_front();
			check("instr_ptr", e.ptr, instr_ptr);
			check("save_reg", e.save, save_reg);
			if (!e.ill) check("holding", e.hold, address_holding_reg);
			check("irq_n", 32'(e.irq_n), 32'(irq_n));
			check("halted", 32'(e.halted), 32'(halted));
			check("stat2", 32'(e.stat2), 32'(interrupt_status_reg[2]));
			check("illegal", 32'(e.ill), 32'(illegal));
			check("req_serviced", 32'(e.srv), 32'(req_serviced));
		end
	end

	// Hang guard
	initial begin
		#60000;
		miscompares++;
		wrap_up();
	end

	// Main sequence
	initial begin
		void'($urandom(32'h42f99946));
		repeat (8) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		for (int o = 0; o < 8; o++) run_one(o);
		$display("opcode sweep done");
		repeat (150) run_one($urandom_range(0, 7));
		$display("random conditions done");
		wrap_up();
	end
endmodule
